// ---- rtl/mtsq_defines.vh ----
// Purpose: constants of the transmit status and queue controller
// Assumes: byte addresses of a 32-bit AXI4-Lite register window
// Notes: offsets use the low 12 address bits
`ifndef MTSQ_DEFINES_VH
`define MTSQ_DEFINES_VH
// Register byte offsets
`define MTSQ_A_EV_KEEP 12'h028
`define MTSQ_A_EV_RDCLR 12'h02C
`define MTSQ_A_BM_CTRL 12'h080
`define MTSQ_A_BM_STATE 12'h084
`define MTSQ_A_RX_DCRED 12'h09C
`define MTSQ_A_RX_SCRED 12'h0AC
`define MTSQ_A_TX_DPTR 12'h0B8
`define MTSQ_A_TX_DCRED 12'h0BC
`define MTSQ_A_TX_SPTR 12'h0C8
`define MTSQ_A_MAX_LEN 12'h0E8
// Bus master control bits
`define MTSQ_C_RX_EN 0
`define MTSQ_C_TX_EN 8
`define MTSQ_C_TX_DIS 9
`define MTSQ_C_HALT_UND 11
`define MTSQ_C_CH_RST 12
// Bus master state bits
`define MTSQ_S_RX_ACT 7
`define MTSQ_S_TX_ACT 3
`define MTSQ_S_TX_HALT 4
`define MTSQ_S_TX_HARD 5
// Event status bits
`define MTSQ_E_RX_WARN 0
`define MTSQ_E_EOC 1
`define MTSQ_E_LEN 2
`define MTSQ_E_UND_HALT 3
`define MTSQ_E_TX_STAT 4
`define MTSQ_E_HARD 5
`define MTSQ_E_W 6
// Transmit status word fields
`define MTSQ_W_FP 31
`define MTSQ_W_CLEAN 30
`define MTSQ_W_ABORT 29
`define MTSQ_W_CRS 28
`define MTSQ_W_LATE 26
`define MTSQ_W_UND 25
`define MTSQ_W_EXC 24
`define MTSQ_W_COLLISION_COUNT_LO 16
`define MTSQ_W_TBI_W 15
// Descriptor word fields
`define MTSQ_D_ABORT 31
`define MTSQ_D_SINGLE 30
`define MTSQ_D_LEN_LO 16
// Limits and reset values
`define MTSQ_LATE_BYTES 7'h3C
`define MTSQ_COLL_LIMIT 5'h10
`define MTSQ_DESC_STEP 32'h0000_0004
`define MTSQ_STAT_STEP 32'h0000_0004
`define MTSQ_MAX_LEN_RST 11'h5F2
// AXI responses
`define MTSQ_OKAY 2'b00
`define MTSQ_SLVERR 2'b10
`endif

// ---- rtl/mtsq_ctrl.v ----
// Purpose: transmit status build, error halts, event status, queue credits
// Assumes: one clock; tx engine and bus master ports on the same clock
// Notes: only mii_crs comes from a pin and is synchronised
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`include "mtsq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// What this block does
// - Every transmit status word written has the processed flag set
// - Clean flag set when a frame finishes with no error at all
// - Descriptor abort command gives the abort flag in the status
// - Carrier lost at preamble end sets the carrier loss flag
// - Collision after more than 60 bytes sets the late flag
// - Data starvation sets the underrun flag
// - Too many collisions, one or sixteen, set the excess flag
// - Status reports how many collisions the frame saw
// - Status copies the buffer index of the first descriptor
// - Credits drive fetch, send, status write and the status event
// - Bus faults halt transmit DMA until chain reset and enable
// - Excess collisions are flagged and the next frame follows
// - Underrun with halt option set halts the descriptor processor
// - Keep view reads unchanged; writing one clears that bit only
// - Read-clear view returns events and clears all of them
// - Fresh enable zeroes credits, keeps pointers, starts nothing
// - Receive active shows once enabled; credits then allow reads
// - Taking the last receive descriptor raises the warning event
// - Taking the last transmit descriptor raises end of chain
// - Overlong frame raises length fault and halts transmit
// - Enable after soft halt resumes at the same positions
// - Chain reset bit clears itself once the reset is done
module mtsq_ctrl #(
	parameter CRED_W = 16,
	parameter LEN_W = 11
) (
	input wire clk,
	input wire nrst,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg desc_req,
	output reg [31:0] desc_addr,
	input wire desc_ack,
	input wire desc_err,
	input wire [31:0] desc_word,
	output reg tx_start,
	output reg [LEN_W-1:0] tx_len,
	output reg tx_abandon,
	input wire tx_byte,
	input wire tx_preamble_end,
	input wire tx_collision,
	input wire tx_underrun,
	input wire tx_done,
	input wire mii_crs,
	output reg stat_req,
	output reg [31:0] stat_addr,
	output reg [31:0] stat_word,
	input wire stat_ack,
	input wire stat_err,
	input wire rx_desc_taken,
	input wire rx_stat_taken
);
	localparam S_IDLE = 5'b00001;
	localparam S_FETCH = 5'b00010;
	localparam S_SEND = 5'b00100;
	localparam S_STAT = 5'b01000;
	localparam S_HALT = 5'b10000;

	reg [4:0] state;
	reg crs_m;
	reg crs_s;
	reg aw_full;
	reg w_full;
	reg [11:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [15:0] bm_ctrl;
	reg rx_act;
	reg tx_fresh;
	reg tx_hard;
	reg und_pend;
	reg [`MTSQ_E_W-1:0] ev;
	reg [CRED_W-1:0] tx_cred;
	reg [CRED_W-1:0] rx_dcred;
	reg [CRED_W-1:0] rx_scred;
	reg [31:0] tx_dptr;
	reg [31:0] tx_sptr;
	reg [LEN_W-1:0] max_len;
	reg [6:0] byte_cnt;
	reg [4:0] collision_count;
	reg [`MTSQ_W_TBI_W-1:0] buffer_index_copy;
	reg single;
	reg f_abort;
	reg f_crs;
	reg f_late;
	reg f_und;
	reg f_exc;
	reg [31:0] rd_val;
	reg rd_hit;
	reg [`MTSQ_E_W-1:0] ev_set;

	wire tx_en = bm_ctrl[`MTSQ_C_TX_EN];
	wire rx_en = bm_ctrl[`MTSQ_C_RX_EN];
	wire ch_rst = bm_ctrl[`MTSQ_C_CH_RST];
	wire wr_go = aw_full & w_full & ~s_axi_bvalid;
	wire ar_go = s_axi_arvalid & s_axi_arready;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] wd = w_data & wmask;
	wire fetch_ok = state[1] & desc_ack & ~desc_err;
	wire fetch_bad = state[1] & desc_ack & desc_err;
	wire stat_ok = state[3] & stat_ack & ~stat_err;
	wire stat_bad = state[3] & stat_ack & stat_err;
	wire [LEN_W-1:0] d_len = desc_word[`MTSQ_D_LEN_LO+LEN_W-1:`MTSQ_D_LEN_LO];
	wire too_long = d_len > max_len;
	wire [4:0] collision_count_inc = collision_count + 5'h01;
	wire exc_hit = single | (collision_count_inc == `MTSQ_COLL_LIMIT);
	wire any_err = f_abort | f_crs | f_late | f_und | f_exc;
	wire rd_clr = ar_go & (s_axi_araddr == `MTSQ_A_EV_RDCLR);
	wire wr_keep = wr_go & (aw_addr == `MTSQ_A_EV_KEEP);
	wire wr_ctrl = wr_go & (aw_addr == `MTSQ_A_BM_CTRL);
	wire tx_rise = wr_ctrl & wd[`MTSQ_C_TX_EN] & ~tx_en;
	wire rx_rise = wr_ctrl & wd[`MTSQ_C_RX_EN] & ~rx_en;
	wire [15:0] ctrl_wr = (bm_ctrl & ~wmask[15:0]) | wd[15:0];
	// Credit taken in the cycle of an enqueue write, so the write cannot hide it
	wire [CRED_W-1:0] txd_take = {{(CRED_W-1){1'b0}}, fetch_ok};
	wire [CRED_W-1:0] rxd_take = {{(CRED_W-1){1'b0}}, rx_desc_taken & (rx_dcred != 0)};
	wire [CRED_W-1:0] rxs_take = {{(CRED_W-1){1'b0}}, rx_stat_taken & (rx_scred != 0)};

	////////////////////////////////////////////////////////////////////
	// Carrier sense pin synchroniser
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crs_m <= 1'b0;
			crs_s <= 1'b0;
		end else begin
			crs_m <= mii_crs;
			crs_s <= crs_m;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Events raised this cycle
	always @* begin
		ev_set = {`MTSQ_E_W{1'b0}};
		ev_set[`MTSQ_E_RX_WARN] = rx_desc_taken & (rx_dcred == 1);
		ev_set[`MTSQ_E_EOC] = fetch_ok & (tx_cred == 1);
		ev_set[`MTSQ_E_LEN] = fetch_ok & too_long;
		ev_set[`MTSQ_E_UND_HALT] = stat_ok & und_pend;
		ev_set[`MTSQ_E_TX_STAT] = stat_ok;
		ev_set[`MTSQ_E_HARD] = fetch_bad | stat_bad;
	end

	////////////////////////////////////////////////////////////////////
	// Register read mux
	always @* begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`MTSQ_A_EV_KEEP: rd_val[`MTSQ_E_W-1:0] = ev;
			`MTSQ_A_EV_RDCLR: rd_val[`MTSQ_E_W-1:0] = ev;
			`MTSQ_A_BM_CTRL: rd_val[15:0] = bm_ctrl;
			`MTSQ_A_BM_STATE: begin
				rd_val[`MTSQ_S_RX_ACT] = rx_act;
				rd_val[`MTSQ_S_TX_ACT] = tx_en & ~state[4];
				rd_val[`MTSQ_S_TX_HALT] = state[4];
				rd_val[`MTSQ_S_TX_HARD] = tx_hard;
			end
			`MTSQ_A_RX_DCRED: rd_val[CRED_W-1:0] = rx_dcred;
			`MTSQ_A_RX_SCRED: rd_val[CRED_W-1:0] = rx_scred;
			`MTSQ_A_TX_DPTR: rd_val = tx_dptr;
			`MTSQ_A_TX_DCRED: rd_val[CRED_W-1:0] = tx_cred;
			`MTSQ_A_TX_SPTR: rd_val = tx_sptr;
			`MTSQ_A_MAX_LEN: rd_val[LEN_W-1:0] = max_len;
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes; write applied one edge after both halves
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MTSQ_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `MTSQ_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			// Address and data halves are taken in either order
			if (s_axi_awvalid & s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_full & !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_full & !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					`MTSQ_A_EV_KEEP, `MTSQ_A_BM_CTRL, `MTSQ_A_RX_DCRED,
					`MTSQ_A_RX_SCRED, `MTSQ_A_TX_DPTR, `MTSQ_A_TX_DCRED,
					`MTSQ_A_TX_SPTR, `MTSQ_A_MAX_LEN: s_axi_bresp <= `MTSQ_OKAY;
					default: s_axi_bresp <= `MTSQ_SLVERR;
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Read answer registered; ready drops until rready
			if (ar_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? `MTSQ_OKAY : `MTSQ_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control registers, credits, descriptor processor
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			bm_ctrl <= 16'h0000;
			rx_act <= 1'b0;
			tx_fresh <= 1'b1;
			tx_hard <= 1'b0;
			und_pend <= 1'b0;
			ev <= {`MTSQ_E_W{1'b0}};
			tx_cred <= {CRED_W{1'b0}};
			rx_dcred <= {CRED_W{1'b0}};
			rx_scred <= {CRED_W{1'b0}};
			tx_dptr <= 32'h0000_0000;
			tx_sptr <= 32'h0000_0000;
			max_len <= `MTSQ_MAX_LEN_RST;
			byte_cnt <= 7'h00;
			collision_count <= 5'h00;
			buffer_index_copy <= {`MTSQ_W_TBI_W{1'b0}};
			single <= 1'b0;
			f_abort <= 1'b0;
			f_crs <= 1'b0;
			f_late <= 1'b0;
			f_und <= 1'b0;
			f_exc <= 1'b0;
			desc_req <= 1'b0;
			desc_addr <= 32'h0000_0000;
			tx_start <= 1'b0;
			tx_len <= {LEN_W{1'b0}};
			tx_abandon <= 1'b0;
			stat_req <= 1'b0;
			stat_addr <= 32'h0000_0000;
			stat_word <= 32'h0000_0000;
		end else begin
			tx_start <= 1'b0;
			tx_abandon <= 1'b0;
			// Sticky events: a new set beats a clear in the same cycle
			ev <= (ev & ~(rd_clr ? ev : {`MTSQ_E_W{1'b0}})
				& ~(wr_keep ? wd[`MTSQ_E_W-1:0] : {`MTSQ_E_W{1'b0}}))
				| ev_set;
			rx_act <= rx_en;
			// Receive credits consumed by the receive engine
			if (rx_desc_taken & (rx_dcred != 0)) begin
				rx_dcred <= rx_dcred - 1'b1;
			end
			if (rx_stat_taken & (rx_scred != 0)) begin
				rx_scred <= rx_scred - 1'b1;
			end
			case (state)
				S_IDLE: begin
					if (tx_en & bm_ctrl[`MTSQ_C_TX_DIS]) begin
						bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
						state <= S_HALT;
					end else if (tx_en & (tx_cred != 0) & ~ch_rst) begin
						desc_req <= 1'b1;
						desc_addr <= tx_dptr;
						state <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (fetch_bad) begin
						desc_req <= 1'b0;
						tx_hard <= 1'b1;
						bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
						state <= S_HALT;
					end else if (fetch_ok) begin
						desc_req <= 1'b0;
						tx_cred <= tx_cred - 1'b1;
						tx_dptr <= tx_dptr + `MTSQ_DESC_STEP;
						buffer_index_copy <= desc_word[`MTSQ_W_TBI_W-1:0];
						single <= desc_word[`MTSQ_D_SINGLE];
						f_abort <= desc_word[`MTSQ_D_ABORT];
						f_crs <= 1'b0;
						f_late <= 1'b0;
						f_und <= 1'b0;
						f_exc <= 1'b0;
						collision_count <= 5'h00;
						byte_cnt <= 7'h00;
						if (too_long) begin
							bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
							state <= S_HALT;
						end else if (desc_word[`MTSQ_D_ABORT]) begin
							state <= S_STAT;
						end else begin
							tx_start <= 1'b1;
							tx_len <= d_len;
							state <= S_SEND;
						end
					end
				end
				S_SEND: begin
					if (tx_byte & (byte_cnt != 7'h7F)) begin
						byte_cnt <= byte_cnt + 7'h01;
					end
					if (tx_preamble_end & ~crs_s) begin
						f_crs <= 1'b1;
					end
					if (tx_collision) begin
						collision_count <= collision_count_inc;
						byte_cnt <= 7'h00;
						if (byte_cnt > `MTSQ_LATE_BYTES) begin
							f_late <= 1'b1;
						end
						if (exc_hit) begin
							f_exc <= 1'b1;
							tx_abandon <= 1'b1;
							state <= S_STAT;
						end
					end else if (tx_underrun) begin
						f_und <= 1'b1;
						und_pend <= bm_ctrl[`MTSQ_C_HALT_UND];
						state <= S_STAT;
					end else if (tx_done) begin
						state <= S_STAT;
					end
				end
				S_STAT: begin
					// Whole status in one word, held until the write ends
					stat_req <= ~stat_ack;
					stat_addr <= tx_sptr;
					stat_word <= 32'h0000_0000;
					stat_word[`MTSQ_W_FP] <= 1'b1;
					stat_word[`MTSQ_W_CLEAN] <= ~any_err;
					stat_word[`MTSQ_W_ABORT] <= f_abort;
					stat_word[`MTSQ_W_CRS] <= f_crs;
					stat_word[`MTSQ_W_LATE] <= f_late;
					stat_word[`MTSQ_W_UND] <= f_und;
					stat_word[`MTSQ_W_EXC] <= f_exc;
					stat_word[`MTSQ_W_COLLISION_COUNT_LO+4:`MTSQ_W_COLLISION_COUNT_LO] <= collision_count;
					stat_word[`MTSQ_W_TBI_W-1:0] <= buffer_index_copy;
					if (stat_bad) begin
						tx_hard <= 1'b1;
						bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
						state <= S_HALT;
					end else if (stat_ok) begin
						tx_sptr <= tx_sptr + `MTSQ_STAT_STEP;
						und_pend <= 1'b0;
						if (und_pend) begin
							bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
							state <= S_HALT;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_HALT: begin
					// Soft halts resume on enable; a hard halt waits for chain reset
					if (tx_en & ~tx_hard & ~ch_rst) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
			// Chain reset completes only in idle or halt, when no bus request is outstanding
			if (ch_rst & (state[0] | state[4])) begin
				bm_ctrl[`MTSQ_C_CH_RST] <= 1'b0;
				bm_ctrl[`MTSQ_C_TX_EN] <= 1'b0;
				tx_cred <= {CRED_W{1'b0}};
				tx_hard <= 1'b0;
				und_pend <= 1'b0;
				tx_fresh <= 1'b1;
				state <= S_IDLE;
			end
			// Software writes come last so they win over hardware updates
			if (wr_go) begin
				case (aw_addr)
					`MTSQ_A_BM_CTRL: begin
						bm_ctrl <= ctrl_wr;
						if (tx_rise & tx_fresh) begin
							tx_cred <= {CRED_W{1'b0}};
							tx_fresh <= 1'b0;
						end
						if (rx_rise) begin
							rx_dcred <= {CRED_W{1'b0}};
							rx_scred <= {CRED_W{1'b0}};
						end
					end
					`MTSQ_A_RX_DCRED: rx_dcred <= rx_dcred + wd[CRED_W-1:0] - rxd_take;
					`MTSQ_A_RX_SCRED: rx_scred <= rx_scred + wd[CRED_W-1:0] - rxs_take;
					`MTSQ_A_TX_DCRED: tx_cred <= tx_cred + wd[CRED_W-1:0] - txd_take;
					`MTSQ_A_TX_DPTR: tx_dptr <= (tx_dptr & ~wmask) | wd;
					`MTSQ_A_TX_SPTR: tx_sptr <= (tx_sptr & ~wmask) | wd;
					`MTSQ_A_MAX_LEN: max_len <= wd[LEN_W-1:0];
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/mtsq_ctrl_assertions.sv ----
// Purpose: port checks on the status and queue controller
// Assumes: one clock, reset active low
// Notes: bound into every controller instance
`timescale 1ns/1ps
`default_nettype none
module mtsq_ctrl_chk (
	input wire clk,
	input wire nrst,
	input wire desc_req,
	input wire [31:0] desc_addr,
	input wire desc_ack,
	input wire desc_err,
	input wire tx_start,
	input wire tx_abandon,
	input wire tx_underrun,
	input wire stat_req,
	input wire [31:0] stat_addr,
	input wire [31:0] stat_word,
	input wire stat_ack,
	input wire stat_err
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic [31:0] last_addr;
	logic had_ack;
	////////////////////////////////////////////////////////////
	// Last accepted status address, for the step check
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last_addr <= 32'h0;
			had_ack <= 1'b0;
		end else if (stat_req && stat_ack && !stat_err) begin
			last_addr <= stat_addr;
			had_ack <= 1'b1;
		end
	end
	// Status entry contents, bus handshakes and fault stop
	a_fp_always: assert property (stat_req |-> stat_word[31])
		else $error("processed flag missing");
	a_clean_only: assert property (stat_req |-> stat_word[30] == (stat_word[29:24] == 6'h0))
		else $error("clean flag disagrees with error flags");
	a_stat_hold: assert property (stat_req && !stat_ack |=> stat_req && $stable(stat_word))
		else $error("status word dropped before ack");
	a_ptr_step: assert property ($rose(stat_req) && had_ack |-> stat_addr == last_addr + 32'h4)
		else $error("status address did not step by one word");
	a_desc_hold: assert property (desc_req && !desc_ack |=> desc_req && $stable(desc_addr))
		else $error("descriptor request dropped early");
	a_hard_stop: assert property (desc_ack && desc_err |=> (!desc_req && !tx_start) [*8])
		else $error("activity after bus fault");
	a_excess_flag: assert property ($rose(tx_abandon) |-> ##[0:4] (stat_req && stat_word[24]))
		else $error("abandoned frame without excess flag");
	a_under_flag: assert property (tx_underrun |-> ##[1:4] (stat_req && stat_word[25]))
		else $error("underrun without underrun flag");
	// Main scenarios reached
	c_clean: cover property (stat_req && stat_word[30]);
	c_abort: cover property (stat_req && stat_word[29]);
	c_fault: cover property (desc_ack && desc_err);
endmodule
bind mtsq_ctrl mtsq_ctrl_chk i_chk (.clk(clk), .nrst(nrst), .desc_req(desc_req),
	.desc_addr(desc_addr), .desc_ack(desc_ack), .desc_err(desc_err), .tx_start(tx_start),
	.tx_abandon(tx_abandon), .tx_underrun(tx_underrun), .stat_req(stat_req),
	.stat_addr(stat_addr), .stat_word(stat_word), .stat_ack(stat_ack), .stat_err(stat_err));
`default_nettype wire

// ---- verification/mtsq_far_end.sv ----
// Purpose: far end model: memory bus and transmit engine
// Assumes: same clock as the controller
// Notes: descriptor reads answer slowly, status writes promptly
`timescale 1ns/1ps
`default_nettype none
module mtsq_far_end (
	input wire logic clk,
	input wire logic desc_req,
	output logic desc_ack,
	output logic desc_err,
	output logic [31:0] desc_word,
	input wire logic stat_req,
	output logic stat_ack,
	output logic stat_err,
	input wire logic tx_start,
	output logic tx_byte,
	output logic tx_pre_end,
	output logic tx_coll,
	output logic tx_under,
	output logic tx_done,
	input wire logic [31:0] cfg_word,
	input wire logic [1:0] cfg_mode,
	input wire logic cfg_bad
);
	logic [1:0] wait_n = 2'h0;
	logic [2:0] phase = 3'h0;
	wire fire = desc_req && !desc_ack && wait_n == 2'h2;
	initial desc_word = 32'h0;
	////////////////////////////////////////////////////////////
	// Memory: stale read data inverted every cycle, so it looks valid every other cycle
	always @(posedge clk) begin
		wait_n <= (desc_req && !desc_ack && !fire) ? wait_n + 2'h1 : 2'h0;
		desc_ack <= fire;
		desc_err <= fire && cfg_bad;
		desc_word <= fire ? cfg_word : ~desc_word;
		stat_ack <= stat_req && !stat_ack;
		stat_err <= 1'b0;
	end
	// Engine: preamble, then one outcome per frame, none in mode 3
	always @(posedge clk) begin
		phase <= tx_start ? 3'h1 : (phase != 3'h0 && phase != 3'h5) ? phase + 3'h1 : 3'h0;
		tx_byte <= phase != 3'h0;
		tx_pre_end <= phase == 3'h2;
		tx_done <= phase == 3'h4 && cfg_mode == 2'h0;
		tx_coll <= phase == 3'h4 && cfg_mode == 2'h1;
		tx_under <= phase == 3'h4 && cfg_mode == 2'h2;
	end
endmodule
`default_nettype wire

// ---- verification/mtsq_ctrl_tb.sv ----
// Purpose: self-checking bench of the status and queue controller
// Assumes: far end model answers descriptors and status writes
// Notes: one bus transfer at a time
`include "mtsq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mtsq_ctrl_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, dword = 32'h0, rd, sptr = 32'h0000_0200, dptr = 32'h0000_0100;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic crs = 1'b1, bad = 1'b0, rx_take = 1'b0;
	logic [1:0] mode = 2'h0, resp;
	wire awready, wready, bvalid, arready, rvalid, desc_req, desc_ack, desc_err, tx_start;
	wire tx_byte, pre_end, coll, und, done, stat_req, stat_ack, stat_err;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, desc_word, stat_addr, stat_word, daddr;
	wire [10:0] tx_len;
	int err_total = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////
	mtsq_ctrl i_dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.desc_req(desc_req), .desc_addr(daddr), .desc_ack(desc_ack), .desc_err(desc_err),
		.desc_word(desc_word), .tx_start(tx_start), .tx_len(tx_len), .tx_abandon(),
		.tx_byte(tx_byte),
		.tx_preamble_end(pre_end), .tx_collision(coll), .tx_underrun(und), .tx_done(done),
		.mii_crs(crs), .stat_req(stat_req), .stat_addr(stat_addr), .stat_word(stat_word),
		.stat_ack(stat_ack), .stat_err(stat_err), .rx_desc_taken(rx_take), .rx_stat_taken(1'b0));
	mtsq_far_end i_far (.clk(clk), .desc_req(desc_req), .desc_ack(desc_ack), .desc_err(desc_err),
		.desc_word(desc_word), .stat_req(stat_req), .stat_ack(stat_ack), .stat_err(stat_err),
		.tx_start(tx_start), .tx_byte(tx_byte), .tx_pre_end(pre_end), .tx_coll(coll),
		.tx_under(und), .tx_done(done), .cfg_word(dword), .cfg_mode(mode), .cfg_bad(bad));
	////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One register transfer; halves released as each is taken
	task automatic bus(input bit we, input logic [11:0] a, input logic [31:0] d);
		bit aw_p;
		bit w_p;
		bit got;
		aw_p = we;
		w_p = we;
		got = 0;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= we;
		wvalid <= we;
		arvalid <= !we;
		bready <= we;
		rready <= !we;
		// No cycle count assumed; only the watchdog ends a stuck transfer
		while (!got) begin
			@(posedge clk);
			if (aw_p && awready) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
			if (!we && arvalid && arready) arvalid <= 1'b0;
			if (we ? (bvalid && !aw_p && !w_p) : (rvalid && !arvalid)) begin
				got = 1;
				resp = we ? bresp : rresp;
				rd = rdata;
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		@(posedge clk);
	endtask
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic poll(input logic [11:0] a, input int b, input logic v);
		int n;
		n = 0;
		bus(0, a, 32'h0);
		while (rd[b] !== v && n < 30) begin
			bus(0, a, 32'h0);
			n++;
		end
		chk("polled bit", {31'h0, rd[b]}, {31'h0, v});
	endtask
	// Enqueue one descriptor, catch its status entry
	task automatic frame(input logic [31:0] dw, input logic [1:0] m, input logic [31:0] exp);
		int n;
		n = 0;
		dword <= dw;
		mode <= m;
		bus(1, `MTSQ_A_TX_DCRED, 32'h0000_0001);
		while (!stat_req && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("status word", stat_word, exp);
		chk("status address", stat_addr, sptr);
		sptr = sptr + `MTSQ_STAT_STEP;
		chk("descriptor address", daddr, dptr);
		chk("frame length", {21'h0, tx_len}, {21'h0, dw[26:16]});
		dptr = dptr + `MTSQ_DESC_STEP;
		while (stat_req && n < 300) begin
			@(posedge clk);
			n++;
		end
		rchk("status pointer", `MTSQ_A_TX_SPTR, sptr);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_regs;
		rchk("max length", `MTSQ_A_MAX_LEN, 32'h0000_05F2);
		chk("read resp", {30'h0, resp}, {30'h0, `MTSQ_OKAY});
		bus(1, 12'h0F0, 32'h0);
		chk("unmapped wresp", {30'h0, resp}, {30'h0, `MTSQ_SLVERR});
		bus(0, 12'h0F0, 32'h0);
		chk("unmapped resp", {30'h0, resp}, {30'h0, `MTSQ_SLVERR});
		chk("unmapped data", rd, 32'h0);
		$display("register test done");
	endtask
	task automatic t_enable;
		bus(1, `MTSQ_A_TX_DPTR, dptr);
		bus(1, `MTSQ_A_TX_SPTR, sptr);
		// Stale credits before the enable must be wiped by it
		bus(1, `MTSQ_A_TX_DCRED, 32'h0000_0003);
		bus(1, `MTSQ_A_RX_DCRED, 32'h0000_0002);
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0101);
		rchk("tx credit", `MTSQ_A_TX_DCRED, 32'h0);
		rchk("rx credit", `MTSQ_A_RX_DCRED, 32'h0);
		repeat (20) @(posedge clk);
		chk("idle fetch", {31'h0, desc_req}, 32'h0);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_RX_ACT, 1'b1);
		bus(1, `MTSQ_A_RX_DCRED, 32'h0000_0001);
		rx_take <= 1'b1;
		@(posedge clk);
		rx_take <= 1'b0;
		repeat (2) @(posedge clk);
		rchk("rx warning", `MTSQ_A_EV_RDCLR, 32'h0000_0001);
		rchk("events gone", `MTSQ_A_EV_KEEP, 32'h0);
		$display("enable test done");
	endtask
	task automatic t_clean;
		frame(32'h0040_1234, 2'h0, 32'hC000_1234);
		rchk("keep view", `MTSQ_A_EV_KEEP, 32'h0000_0012);
		rchk("keep twice", `MTSQ_A_EV_KEEP, 32'h0000_0012);
		bus(1, `MTSQ_A_EV_KEEP, 32'h0000_0010);
		rchk("one cleared", `MTSQ_A_EV_RDCLR, 32'h0000_0002);
		rchk("all cleared", `MTSQ_A_EV_KEEP, 32'h0);
		$display("clean frame test done");
	endtask
	task automatic t_flags;
		frame(32'h8040_0007, 2'h0, 32'hA000_0007);
		crs <= 1'b0;
		frame(32'h0040_0021, 2'h0, 32'h9000_0021);
		crs <= 1'b1;
		frame(32'h4040_0033, 2'h1, 32'h8101_0033);
		bus(0, `MTSQ_A_BM_STATE, 32'h0);
		chk("no halt", {31'h0, rd[`MTSQ_S_TX_HALT]}, 32'h0);
		$display("flag test done");
	endtask
	task automatic t_underrun;
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0901);
		frame(32'h0040_0044, 2'h2, 32'h8200_0044);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_TX_HALT, 1'b1);
		rchk("underrun event", `MTSQ_A_EV_RDCLR, 32'h0000_001A);
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0101);
		rchk("resume point", `MTSQ_A_TX_DPTR, dptr);
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0301);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_TX_HALT, 1'b1);
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0101);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_TX_ACT, 1'b1);
		rchk("resume after disable", `MTSQ_A_TX_DPTR, dptr);
		$display("underrun test done");
	endtask
	task automatic t_length;
		bus(1, `MTSQ_A_MAX_LEN, 32'h0000_0020);
		dword <= 32'h0040_0055;
		bus(1, `MTSQ_A_TX_DCRED, 32'h0000_0001);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_TX_HALT, 1'b1);
		chk("no status", {31'h0, stat_req}, 32'h0);
		rchk("length event", `MTSQ_A_EV_RDCLR, 32'h0000_0006);
		bus(1, `MTSQ_A_MAX_LEN, 32'h0000_05F2);
		$display("length test done");
	endtask
	task automatic t_hard;
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0101);
		bad <= 1'b1;
		bus(1, `MTSQ_A_TX_DCRED, 32'h0000_0001);
		poll(`MTSQ_A_BM_STATE, `MTSQ_S_TX_HARD, 1'b1);
		// Credit is still pending, so a plain enable must not restart fetching
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_0101);
		repeat (20) @(posedge clk);
		chk("no refetch", {31'h0, desc_req}, 32'h0);
		bad <= 1'b0;
		bus(1, `MTSQ_A_BM_CTRL, 32'h0000_1001);
		poll(`MTSQ_A_BM_CTRL, `MTSQ_C_CH_RST, 1'b0);
		rchk("credit after chain reset", `MTSQ_A_TX_DCRED, 32'h0);
		$display("hard error test done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#100us;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs;
		t_enable;
		t_clean;
		t_flags;
		t_underrun;
		t_length;
		t_hard;
		complete_run;
	end
endmodule
`default_nettype wire
